// file: include/ufdma_pkg.sv
// Functional notes
// RL1 - mode 0: tx request low when empty
// RL2 - mode 0: rx request low when data held
// RL3 - mode 0: rx request high when empty
// RL4 - mode 1: tx request high only when full
// RL5 - mode 1: rx request low at trigger/timeout
// RL6 - mode 1: rx request held until empty
// RL7 - mode 1: tx interrupt when fifo empties
// RL8 - rx interrupt at trigger, keep filling
// RL9 - trigger codes select 1, 4, 8, 14
// RL10 - control bit 3 selects dma mode
// RL11 - control bits 5:4 unused, zero
// RL12 - bit 2 flushes tx fifo, self-clears
// RL13 - bit 1 flushes rx fifo, self-clears
// RL14 - bit 0 enables both fifos, reset off
// RL15 - other bits written only with bit 0
// RL16 - rx trigger status clears below level
// RL17 - status top bits show fifo enable
// RL18 - sixteen entries, counter-based full/empty
package ufdma_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] UFDMA_OFF_DATA = 8'h00; // tx load, rx read
    localparam logic [7:0] UFDMA_OFF_ISTAT = 8'h04; // interrupt_status, read only
    localparam logic [7:0] UFDMA_OFF_FCTRL = 8'h08; // fifo_control, write only
    localparam logic [7:0] UFDMA_OFF_EVT = 8'h0c; // sticky events, read only
    localparam logic [7:0] UFDMA_OFF_EVT_EN = 8'h10; // event enable
    localparam logic [7:0] UFDMA_OFF_EVT_CLR = 8'h14; // event clear, write one
    localparam logic [7:0] UFDMA_OFF_LEVEL = 8'h18; // counts and mode, read only

    ////////////////////////////////////////////////////////////////////////////
    // fifo_control field positions
    localparam int UFDMA_FC_ENABLE = 0;
    localparam int UFDMA_FC_RX_FLUSH = 1;
    localparam int UFDMA_FC_TX_FLUSH = 2;
    localparam int UFDMA_FC_DMA_MODE = 3;
    localparam int UFDMA_FC_THR_LSB = 6;

    // reset values
    localparam logic [1:0] UFDMA_THR_RESET = 2'h0;
    localparam logic UFDMA_MODE_RESET = 1'b0;
    localparam logic UFDMA_ENABLE_RESET = 1'b0;

    // depth and thresholds
    localparam int UFDMA_DEPTH = 16;
    localparam logic [4:0] UFDMA_THR_1 = 5'h01;
    localparam logic [4:0] UFDMA_THR_4 = 5'h04;
    localparam logic [4:0] UFDMA_THR_8 = 5'h08;
    localparam logic [4:0] UFDMA_THR_14 = 5'h0e;

    // interrupt_status codes, bits 3:0
    localparam logic [3:0] UFDMA_IS_NONE = 4'h1;
    localparam logic [3:0] UFDMA_IS_RX_TRIG = 4'h4;
    localparam logic [3:0] UFDMA_IS_RX_TOUT = 4'hc;
    localparam logic [3:0] UFDMA_IS_TX_EMPTY = 4'h2;

    // sticky event bit positions
    localparam int UFDMA_EV_RX_TRIG = 0;
    localparam int UFDMA_EV_TX_EMPTY = 1;
    localparam int UFDMA_EV_RX_TOUT = 2;
    localparam int UFDMA_EV_RX_OVER = 3;
    localparam int UFDMA_EV_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // apb request carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ufdma_apb_req_type;

    // char from the rx shifter
    typedef struct packed {
        logic valid;
        logic timeout;
        logic [7:0] data;
    } ufdma_rx_in_type;

endpackage : ufdma_pkg

// file: hw/ufdma_top.sv
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ufdma_top
    import ufdma_pkg::*;
#(
    parameter int DEPTH = UFDMA_DEPTH
)
(
    input wire logic i_clock, // 100 MHz
    input wire logic i_reset_n, // async, active low
    input wire ufdma_apb_req_type i_apb, // apb request
    output logic [31:0] o_prdata, // apb read data
    output logic o_pready, // apb ready
    output logic o_pslverr, // apb error, unmapped address
    output logic o_tx_valid, // char offered to tx shifter
    output logic [7:0] o_tx_data, // char for tx shifter
    input wire logic i_tx_ready, // tx shifter takes char
    input wire ufdma_rx_in_type i_rx, // char or timeout from rx shifter
    output logic o_tx_dma_request_n, // transmit ready, active low
    output logic o_rx_dma_request_n, // receive ready, active low
    output logic o_irq // level interrupt
);

    localparam int CW = $clog2(DEPTH + 1);
    localparam int AW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // reset synchroniser
    logic [1:0] reset_sync;
    logic rst_n;
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            reset_sync <= 2'h0;
        else
            reset_sync <= {reset_sync[0], 1'b1};
    end
    assign rst_n = reset_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    logic setup_ph, access_ph, wr_en, rd_en, mapped;
    assign setup_ph = i_apb.psel && !i_apb.penable;
    assign access_ph = i_apb.psel && i_apb.penable && o_pready;
    assign wr_en = access_ph && i_apb.pwrite;
    assign rd_en = access_ph && !i_apb.pwrite;
    assign mapped = (i_apb.paddr <= UFDMA_OFF_LEVEL) && (i_apb.paddr[1:0] == 2'h0);

    logic fc_write, data_write, data_read, istat_read;
    assign fc_write = wr_en && i_apb.paddr == UFDMA_OFF_FCTRL;
    assign data_write = wr_en && i_apb.paddr == UFDMA_OFF_DATA;
    assign data_read = rd_en && i_apb.paddr == UFDMA_OFF_DATA;
    assign istat_read = rd_en && i_apb.paddr == UFDMA_OFF_ISTAT;

    ////////////////////////////////////////////////////////////////////////////
    // fifo_control fields
    logic fifo_en, dma_mode;
    logic [1:0] thr_sel;
    logic tx_flush, rx_flush;
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fifo_en <= UFDMA_ENABLE_RESET;
            dma_mode <= UFDMA_MODE_RESET;
            thr_sel <= UFDMA_THR_RESET;
        end
        else if (fc_write)
        begin
            // RL14 enable both fifos
            fifo_en <= i_apb.pwdata[UFDMA_FC_ENABLE];
            // RL15 other bits gated
            if (i_apb.pwdata[UFDMA_FC_ENABLE])
            begin
                // RL10 dma mode bit
                dma_mode <= i_apb.pwdata[UFDMA_FC_DMA_MODE];
                // RL9 RL11 code, bits 5:4 dropped
                thr_sel <= i_apb.pwdata[UFDMA_FC_THR_LSB +: 2];
            end
        end
    end

    // flush bits are pulses, so they self-clear
    // RL12 tx flush strobe
    assign tx_flush = fc_write && i_apb.pwdata[UFDMA_FC_ENABLE] && i_apb.pwdata[UFDMA_FC_TX_FLUSH];
    // RL13 rx flush strobe
    assign rx_flush = fc_write && i_apb.pwdata[UFDMA_FC_ENABLE] && i_apb.pwdata[UFDMA_FC_RX_FLUSH];

    // RL9 threshold decode
    logic [4:0] thr_level;
    always_comb
    begin
        unique case (thr_sel)
            2'h0: thr_level = UFDMA_THR_1;
            2'h1: thr_level = UFDMA_THR_4;
            2'h2: thr_level = UFDMA_THR_8;
            2'h3: thr_level = UFDMA_THR_14;
        endcase
    end

    // non-fifo mode is a one-entry holding register
    logic [CW-1:0] cap;
    assign cap = fifo_en ? CW'(DEPTH) : CW'(1);

    ////////////////////////////////////////////////////////////////////////////
    // fifo storage
    logic [CW-1:0] tx_count, rx_count;
    logic [AW-1:0] tx_rd, tx_wr, rx_rd, rx_wr;
    logic [7:0] tx_mem [DEPTH];
    logic [7:0] rx_mem [DEPTH];
    logic tx_push, tx_pop, rx_push, rx_pop, rx_over;
    // writes to a full tx fifo drop
    assign tx_push = data_write && tx_count < cap;
    assign tx_pop = o_tx_valid && i_tx_ready;
    // RL8 fills past trigger until full
    assign rx_push = i_rx.valid && rx_count < cap;
    assign rx_over = i_rx.valid && rx_count >= cap;
    assign rx_pop = data_read && rx_count != '0;

    always_ff @(posedge i_clock)
    begin
        if (tx_push)
            tx_mem[tx_wr] <= i_apb.pwdata[7:0];
        if (rx_push)
            rx_mem[rx_wr] <= i_rx.data;
    end

    // RL18 occupancy counters reset by flush
    // enable change flushes: capacity moves under the pointers
    logic en_change;
    assign en_change = fc_write && (i_apb.pwdata[UFDMA_FC_ENABLE] != fifo_en);
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_count <= '0;
            tx_rd <= '0;
            tx_wr <= '0;
        end
        // RL12 flush clears tx count and pointers
        else if (tx_flush || en_change)
        begin
            tx_count <= '0;
            tx_rd <= '0;
            tx_wr <= '0;
        end
        else
        begin
            if (tx_push)
                tx_wr <= AW'(tx_wr + 1'b1);
            if (tx_pop)
                tx_rd <= AW'(tx_rd + 1'b1);
            tx_count <= CW'(tx_count + CW'(tx_push) - CW'(tx_pop));
        end
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_count <= '0;
            rx_rd <= '0;
            rx_wr <= '0;
        end
        // RL13 flush clears rx count and pointers
        else if (rx_flush || en_change)
        begin
            rx_count <= '0;
            rx_rd <= '0;
            rx_wr <= '0;
        end
        else
        begin
            if (rx_push)
                rx_wr <= AW'(rx_wr + 1'b1);
            if (rx_pop)
                rx_rd <= AW'(rx_rd + 1'b1);
            rx_count <= CW'(rx_count + CW'(rx_push) - CW'(rx_pop));
        end
    end

    // head of tx fifo, registered
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_tx_valid <= 1'b0;
            o_tx_data <= 8'h00;
        end
        else
        begin
            o_tx_valid <= tx_count > CW'(tx_pop) && !tx_flush && !en_change;
            o_tx_data <= tx_pop ? tx_mem[AW'(tx_rd + 1'b1)] : tx_mem[tx_rd];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt conditions
    logic rx_trig, tx_empty_pend, tout_pend;
    // RL16 status tracks count against threshold
    assign rx_trig = fifo_en ? (rx_count >= CW'(thr_level)) : (rx_count != '0);

    // RL7 tx empty, cleared by status read or load
    logic tx_empty_edge;
    assign tx_empty_edge = tx_pop && tx_count == CW'(1);
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            tx_empty_pend <= 1'b0;
        else if (tx_empty_edge)
            tx_empty_pend <= 1'b1;
        else if (tx_push || (istat_read && !rx_trig && !tout_pend))
            tx_empty_pend <= 1'b0;
    end

    // timeout pending until a pop or flush
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            tout_pend <= 1'b0;
        else if (i_rx.timeout && fifo_en)
            tout_pend <= 1'b1;
        else if (rx_pop || rx_flush || en_change)
            tout_pend <= 1'b0;
    end

    // RL17 top bits show fifo enable
    logic [7:0] istat;
    always_comb
    begin
        istat = {fifo_en, fifo_en, 2'h0, UFDMA_IS_NONE};
        if (tout_pend)
            istat[3:0] = UFDMA_IS_RX_TOUT;
        else if (rx_trig)
            istat[3:0] = UFDMA_IS_RX_TRIG;
        else if (tx_empty_pend)
            istat[3:0] = UFDMA_IS_TX_EMPTY;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky events; set wins over clear
    logic [UFDMA_EV_W-1:0] evt, evt_en, evt_set;
    logic rx_trig_q;
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            rx_trig_q <= 1'b0;
        else
            rx_trig_q <= rx_trig;
    end
    // RL8 trigger reached raises receive event
    assign evt_set = {rx_over, i_rx.timeout && fifo_en, tx_empty_edge, rx_trig && !rx_trig_q};

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            evt <= '0;
        else if (wr_en && i_apb.paddr == UFDMA_OFF_EVT_CLR)
            evt <= (evt & ~i_apb.pwdata[UFDMA_EV_W-1:0]) | evt_set;
        else
            evt <= evt | evt_set;
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            evt_en <= '0;
        else if (wr_en && i_apb.paddr == UFDMA_OFF_EVT_EN)
            evt_en <= i_apb.pwdata[UFDMA_EV_W-1:0];
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            o_irq <= 1'b0;
        else
            o_irq <= |(evt & evt_en);
    end

    ////////////////////////////////////////////////////////////////////////////
    // dma request pins, a cycle after counts
    logic rx_dma_hold;
    // RL6 mode 1 request held until empty
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            rx_dma_hold <= 1'b0;
        // RL5 set at trigger or timeout
        else if (rx_trig || tout_pend)
            rx_dma_hold <= 1'b1;
        else if (rx_count == '0)
            rx_dma_hold <= 1'b0;
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_tx_dma_request_n <= 1'b0;
            o_rx_dma_request_n <= 1'b1;
        end
        else if (fifo_en && dma_mode)
        begin
            // RL4 high only when full
            o_tx_dma_request_n <= tx_count == CW'(DEPTH);
            o_rx_dma_request_n <= !(rx_trig || tout_pend || (rx_dma_hold && rx_count != '0));
        end
        else
        begin
            // RL1 low while tx empty
            o_tx_dma_request_n <= tx_count != '0;
            // RL2 low while data held
            // RL3 high again once empty
            o_rx_dma_request_n <= rx_count == '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb response, zero wait states; reads mux in setup phase
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (i_apb.paddr)
            UFDMA_OFF_DATA: rd_mux = {24'h00_0000, rx_mem[rx_rd]};
            UFDMA_OFF_ISTAT: rd_mux = {24'h00_0000, istat};
            UFDMA_OFF_EVT: rd_mux = {28'h000_0000, evt};
            UFDMA_OFF_EVT_EN: rd_mux = {28'h000_0000, evt_en};
            UFDMA_OFF_LEVEL: rd_mux = {8'h00, thr_sel, 2'h0, dma_mode, 2'h0, fifo_en,
                                       3'h0, 5'(rx_count), 3'h0, 5'(tx_count)};
            default: rd_mux = 32'h0000_0000;
        endcase
        // empty rx reads zero
        if (rx_count == '0 && i_apb.paddr == UFDMA_OFF_DATA)
            rd_mux = 32'h0000_0000;
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready <= setup_ph;
            o_pslverr <= setup_ph && !mapped;
            if (setup_ph)
                o_prdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_tx_mode0;
        @(posedge i_clock) disable iff (!rst_n)
        !(fifo_en && dma_mode) |=> o_tx_dma_request_n == ($past(tx_count) != '0);
    endproperty
    a_tx_mode0: assert property (p_tx_mode0) else $error("tx req mode 0"); // RL1
    property p_rx_mode0_low;
        @(posedge i_clock) disable iff (!rst_n)
        !fifo_en && rx_count != '0 |=> !o_rx_dma_request_n;
    endproperty
    a_rx_mode0_low: assert property (p_rx_mode0_low) else $error("rx req high with data"); // RL2
    property p_rx_mode0_high;
        @(posedge i_clock) disable iff (!rst_n)
        !dma_mode && rx_count == '0 |=> o_rx_dma_request_n;
    endproperty
    a_rx_mode0_high: assert property (p_rx_mode0_high) else $error("rx req low when empty"); // RL3
    property p_tx_mode1;
        @(posedge i_clock) disable iff (!rst_n)
        fifo_en && dma_mode |=> o_tx_dma_request_n == ($past(tx_count) == CW'(DEPTH));
    endproperty
    a_tx_mode1: assert property (p_tx_mode1) else $error("tx req mode 1"); // RL4
    property p_rx_mode1_trig;
        @(posedge i_clock) disable iff (!rst_n)
        fifo_en && dma_mode && rx_count >= CW'(thr_level) |=> !o_rx_dma_request_n;
    endproperty
    a_rx_mode1_trig: assert property (p_rx_mode1_trig) else $error("rx req missed trigger"); // RL5
    property p_rx_mode1_hold;
        @(posedge i_clock) disable iff (!rst_n)
        fifo_en && dma_mode && !o_rx_dma_request_n && rx_count != '0 |=> !o_rx_dma_request_n;
    endproperty
    a_rx_mode1_hold: assert property (p_rx_mode1_hold) else $error("rx req released early"); // RL6
    property p_tx_empty;
        @(posedge i_clock) disable iff (!rst_n)
        tx_empty_edge |=> evt[UFDMA_EV_TX_EMPTY] && tx_empty_pend;
    endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("tx empty event lost"); // RL7
    property p_flush;
        @(posedge i_clock) disable iff (!rst_n)
        tx_flush |=> tx_count == '0 ##1 !o_tx_dma_request_n;
    endproperty
    a_flush: assert property (p_flush) else $error("tx flush failed"); // RL12
    property p_gate;
        @(posedge i_clock) disable iff (!rst_n)
        fc_write && !i_apb.pwdata[UFDMA_FC_ENABLE] |=> $stable(dma_mode) && $stable(thr_sel) && !fifo_en;
    endproperty
    a_gate: assert property (p_gate) else $error("fields changed without enable"); // RL15
    property p_istat_top;
        @(posedge i_clock) disable iff (!rst_n)
        istat_read |=> o_prdata[7:6] == {2{$past(fifo_en, 2)}};
    endproperty
    a_istat_top: assert property (p_istat_top) else $error("status top bits wrong"); // RL17

    c_mode1_trig: cover property (@(posedge i_clock) fifo_en && dma_mode && !o_rx_dma_request_n);
    c_tx_full: cover property (@(posedge i_clock) tx_count == CW'(DEPTH));
    c_rx_flush: cover property (@(posedge i_clock) rx_flush && rx_count != '0);
    c_irq: cover property (@(posedge i_clock) o_irq);

endmodule : ufdma_top

// file: tb/ufdma_shifter_model.sv
`timescale 1ns/1ps
module ufdma_shifter_model
    import ufdma_pkg::*;
(
    input wire logic i_clock, // system clock
    input wire logic i_stall, // hold off tx
    input wire logic i_tx_valid, // char offered by the block
    input wire logic [7:0] i_tx_data, // offered char
    output logic o_tx_ready, // takes the offered char
    output ufdma_rx_in_type o_rx // rx char or timeout pulse
);
    logic [7:0] tx_seen[$];
    logic phase;

    initial
    begin
        phase = 1'b0;
        o_tx_ready = 1'b0;
        o_rx = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // take every other cycle so the fifo drains slowly
    always @(posedge i_clock)
    begin
        phase <= ~phase;
        o_tx_ready <= ~i_stall & phase;
        if (i_tx_valid && o_tx_ready)
            tx_seen.push_back(i_tx_data);
    end

    ////////////////////////////////////////////////////////////////////////////
    // one-cycle pulse; data inverted after it
    task automatic send(input logic tout, input logic [7:0] d);
        @(posedge i_clock);
        o_rx <= '{valid: ~tout, timeout: tout, data: d};
        @(posedge i_clock);
        o_rx <= '{valid: 1'b0, timeout: 1'b0, data: ~d};
    endtask : send
endmodule : ufdma_shifter_model

// file: tb/uart_fifo_control_dma_signalling_test.sv
`timescale 1ns/1ps
module uart_fifo_control_dma_signalling_test
    import ufdma_pkg::*;
;
    logic i_clock, i_reset_n, pready, pslverr, tx_valid, tx_ready, tx_n, rx_n, irq, stall, rerr;
    ufdma_apb_req_type apb;
    ufdma_rx_in_type rx;
    logic [31:0] prdata, rdat, seed;
    logic [7:0] tx_data;
    logic [7:0] rxq[$], txq[$];
    int err_count, checked;

    ufdma_top #(.DEPTH(UFDMA_DEPTH)) DUT (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_apb(apb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_tx_valid(tx_valid),
        .o_tx_data(tx_data), .i_tx_ready(tx_ready), .i_rx(rx), .o_tx_dma_request_n(tx_n),
        .o_rx_dma_request_n(rx_n), .o_irq(irq));
    ufdma_shifter_model SHIFT (.i_clock(i_clock), .i_stall(stall), .i_tx_valid(tx_valid),
        .i_tx_data(tx_data), .o_tx_ready(tx_ready), .o_rx(rx));

    ////////////////////////////////////////////////////////////////////////////
    // expectations
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd
    function automatic int thr_of(input int c);
        int t[4] = '{1, 4, 8, 14};
        return t[c];
    endfunction : thr_of
    // bit 0 always set so other fields take
    function automatic logic [31:0] fifo_control(input logic [1:0] c, input logic m, input logic rf, input logic tf);
        return {24'h0, c, 2'b00, m, tf, rf, 1'b1};
    endfunction : fifo_control
    function automatic logic [31:0] istat_exp(input logic en, input logic [3:0] src);
        return {24'h0, en, en, 2'b00, src};
    endfunction : istat_exp

    ////////////////////////////////////////////////////////////////////////////
    // checks and verdict
    task automatic summarize();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            $display("ERROR %s expected %b seen %b", nm, e, g);
            err_count++;
        end
    endtask : cmp_bit
    task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : cmp_word

    ////////////////////////////////////////////////////////////////////////////
    // apb master: hold request until pready sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge i_clock);
        apb.penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge i_clock);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            err_count++;
            summarize();
        end
        rdat = prdata;
        rerr = pslverr;
        apb <= '0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask : rd
    // request pins lag counts a cycle
    task automatic settle();
        repeat (3) @(posedge i_clock);
        #1;
    endtask : settle
    task automatic set_stall(input logic v);
        @(posedge i_clock);
        stall <= v;
    endtask : set_stall
    task automatic push(input int n);
        logic [7:0] d;
        repeat (n)
        begin
            d = rnd();
            rxq.push_back(d);
            SHIFT.send(1'b0, d);
        end
    endtask : push
    task automatic pop_chk();
        rd(UFDMA_OFF_DATA);
        cmp_word("rx data", {24'h0, rxq.pop_front()}, rdat & 32'hff);
    endtask : pop_chk
    task automatic tx_chk();
        while (txq.size() > 0)
            cmp_word("tx char", {24'h0, txq.pop_front()}, {24'h0, SHIFT.tx_seen.pop_front()});
    endtask : tx_chk

    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    // a hung run ends as a failure
    initial
    begin
        #900000;
        err_count++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int n;
        i_reset_n = 1'b0;
        apb = '0;
        stall = 1'b1;
        seed = 32'h3ba7;
        err_count = 0;
        checked = 0;
        repeat (3) @(posedge i_clock);
        i_reset_n <= 1'b1;
        settle();
        cmp_bit("tx req reset", 1'b0, tx_n);
        cmp_bit("rx req reset", 1'b1, rx_n);
        rd(UFDMA_OFF_ISTAT);
        cmp_word("istat reset", istat_exp(1'b0, UFDMA_IS_NONE), rdat);
        rd(UFDMA_OFF_LEVEL);
        cmp_word("level reset", 32'h0, rdat);
        // non-fifo holding registers
        txq.push_back(8'h5a);
        wr(UFDMA_OFF_DATA, 32'h5a);
        settle();
        cmp_bit("tx req loaded", 1'b1, tx_n);
        set_stall(1'b0);
        settle();
        cmp_bit("tx req drained", 1'b0, tx_n);
        tx_chk();
        push(1);
        settle();
        cmp_bit("rx req held char", 1'b0, rx_n);
        pop_chk();
        settle();
        cmp_bit("rx req none", 1'b1, rx_n);
        // each trigger code in mode 1, bits 5:4 set
        for (int c = 0; c < 4; c++)
        begin
            wr(UFDMA_OFF_FCTRL, fifo_control(c[1:0], 1'b1, 1'b1, 1'b1) | 32'h30);
            wr(UFDMA_OFF_EVT_CLR, 32'hf);
            push(thr_of(c) - 1);
            settle();
            cmp_bit("rx req below trig", 1'b1, rx_n);
            push(1);
            settle();
            cmp_bit("rx req at trig", 1'b0, rx_n);
            rd(UFDMA_OFF_ISTAT);
            cmp_word("istat trig", istat_exp(1'b1, UFDMA_IS_RX_TRIG), rdat);
            rd(UFDMA_OFF_EVT);
            cmp_bit("trig event", 1'b1, rdat[UFDMA_EV_RX_TRIG]);
            rd(UFDMA_OFF_LEVEL);
            cmp_word("trig code mode", 32'(c) | 32'h4, {29'h0, rdat[19], rdat[23:22]});
            pop_chk();
            settle();
            cmp_bit("rx req kept", thr_of(c) == 1, rx_n);
            rd(UFDMA_OFF_ISTAT);
            cmp_bit("trig status gone", 1'b0, rdat[3:0] === UFDMA_IS_RX_TRIG);
            while (rxq.size() > 0)
                pop_chk();
            settle();
            cmp_bit("rx req empty", 1'b1, rx_n);
        end
        // fill past full, then flush
        push(UFDMA_DEPTH + 1);
        rd(UFDMA_OFF_LEVEL);
        cmp_word("rx count full", 32'(UFDMA_DEPTH), {27'h0, rdat[12:8]});
        rd(UFDMA_OFF_EVT);
        cmp_bit("overrun event", 1'b1, rdat[UFDMA_EV_RX_OVER]);
        wr(UFDMA_OFF_FCTRL, fifo_control(2'h3, 1'b1, 1'b1, 1'b0));
        rxq.delete();
        settle();
        cmp_bit("rx req flushed", 1'b1, rx_n);
        push(1);
        rd(UFDMA_OFF_LEVEL);
        cmp_word("rx count flushed", 32'h1, {27'h0, rdat[12:8]});
        SHIFT.send(1'b1, 8'h00);
        settle();
        cmp_bit("rx req timeout", 1'b0, rx_n);
        rd(UFDMA_OFF_ISTAT);
        cmp_word("istat timeout", istat_exp(1'b1, UFDMA_IS_RX_TOUT), rdat);
        pop_chk();
        settle();
        cmp_bit("rx req timeout empty", 1'b1, rx_n);
        // tx fill, flush, block drain
        set_stall(1'b1);
        for (int i = 0; i < UFDMA_DEPTH; i++)
        begin
            settle();
            cmp_bit("tx req not full", 1'b0, tx_n);
            wr(UFDMA_OFF_DATA, rnd() & 32'hff);
        end
        settle();
        cmp_bit("tx req full", 1'b1, tx_n);
        wr(UFDMA_OFF_FCTRL, fifo_control(2'h0, 1'b1, 1'b0, 1'b1));
        settle();
        cmp_bit("tx req flushed", 1'b0, tx_n);
        rd(UFDMA_OFF_LEVEL);
        cmp_word("tx count flushed", 32'h0, {27'h0, rdat[4:0]});
        wr(UFDMA_OFF_EVT_CLR, 32'hf);
        wr(UFDMA_OFF_EVT_EN, 32'h1 << UFDMA_EV_TX_EMPTY);
        repeat (3)
        begin
            txq.push_back(rnd());
            wr(UFDMA_OFF_DATA, {24'h0, txq[$]});
        end
        set_stall(1'b0);
        for (n = 0; n < 60 && SHIFT.tx_seen.size() < 3; n++)
            @(posedge i_clock);
        if (n == 60)
        begin
            err_count++;
            summarize();
        end
        settle();
        cmp_bit("irq tx empty", 1'b1, irq);
        rd(UFDMA_OFF_ISTAT);
        cmp_word("istat tx empty", istat_exp(1'b1, UFDMA_IS_TX_EMPTY), rdat);
        tx_chk();
        wr(UFDMA_OFF_EVT_EN, 32'h0);
        settle();
        cmp_bit("irq masked", 1'b0, irq);
        wr(UFDMA_OFF_EVT_EN, 32'h1 << UFDMA_EV_TX_EMPTY);
        settle();
        cmp_bit("irq unmasked", 1'b1, irq);
        wr(UFDMA_OFF_EVT_CLR, 32'h1 << UFDMA_EV_TX_EMPTY);
        settle();
        cmp_bit("irq cleared", 1'b0, irq);
        // bit 0 clear: only the enable changes
        wr(UFDMA_OFF_FCTRL, 32'hc0);
        rd(UFDMA_OFF_LEVEL);
        cmp_word("fields kept", 32'h00080000, rdat & 32'h00c90000);
        rd(UFDMA_OFF_ISTAT);
        cmp_bit("istat fifo bits off", 1'b1, rdat[7:6] === 2'b00);
        rd(8'h1c);
        cmp_bit("unmapped err", 1'b1, rerr);
        cmp_word("unmapped data", 32'h0, rdat);
        wr(8'h02, 32'hff);
        cmp_bit("misaligned err", 1'b1, rerr);
        summarize();
    end
endmodule : uart_fifo_control_dma_signalling_test
